// file: dv/bis_chk.sv
// Checker for bis_steer
`timescale 1ns/100ps
module bis_chk (
	input wire logic clock_i, reset_i, cfg_wr_i, pin0_in_i, pin0_out_o, pin0_oe_o,
	input wire logic timer_irq_i, ide_irq_set_o,
	input wire logic [7:0] cfg_addr_i, cfg_wdata_i, cfg_rdata_o,
	input wire logic [15:0] isa_irq_i, ctl_irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	wire w0 = cfg_wr_i && cfg_addr_i == 8'h70; // Write to first route
	a_rsvd_zero: assert property (!cfg_rdata_o[4]) else $error("bit4");
	a_unmapped_zero: assert property (cfg_addr_i[7:1] != 7'h38 |-> !cfg_rdata_o)
		else $error("addr");
	a_write_read: assert property (w0 ##1 cfg_addr_i == 8'h70
		|-> cfg_rdata_o == ($past(cfg_wdata_i) & 8'hef)) else $error("read");
	a_write_mode: assert property (w0 |=> ##1 pin0_oe_o == $past(cfg_wdata_i[5], 2))
		else $error("mode");
	a_timer_out: assert property (pin0_out_o == (pin0_oe_o & $past(timer_irq_i)))
		else $error("timer");
	a_ide_timer: assert property (pin0_oe_o |-> ide_irq_set_o == $past(isa_irq_i[15], 3))
		else $error("ide15");
	a_ide_board: assert property (!pin0_oe_o |-> ide_irq_set_o == $past(pin0_in_i, 3))
		else $error("idepin");
	a_reset_quiet: assert property ($fell(reset_i) |-> !ctl_irq_o && !pin0_oe_o)
		else $error("reset");
	c_timer: cover property (pin0_oe_o);
	c_route: cover property (|ctl_irq_o);
	c_write: cover property (w0);
endmodule
bind bis_steer bis_chk u_chk (.*);

// file: dv/bis_far.sv
// Far side interrupt sources
`timescale 1ns/100ps
module bis_far (input wire logic clock_i, input wire logic [18:0] want_i,
	output logic [18:0] lvl_o = 0);
	always @(negedge clock_i) lvl_o <= want_i;
endmodule

// file: dv/tb_top.sv
// Bench for bis_steer
`timescale 1ns/100ps
module tb_top;
	logic clock_i = 0, reset_i = 1, cfg_wr_i = 0, pin0_out_o, pin0_oe_o, ide_irq_set_o;
	logic [7:0] cfg_addr_i = 8'h70, cfg_wdata_i = 0, cfg_rdata_o, r0, r1;
	logic [15:0] ctl_irq_o;
	logic [18:0] want_i = 0, lvl_o;
	int n_mismatch = 0, comparisons = 0;
	bis_far far (.*);
	bis_steer dut (.*, .pin0_in_i(pin0_oe_o ? pin0_out_o : lvl_o[16]),
		.board_irq_in_1_i(lvl_o[17]), .timer_irq_i(lvl_o[18]), .isa_irq_i(lvl_o[15:0]));
	initial forever #2.5 clock_i = ~clock_i;
	// Controller inputs: masked ISA lines or board drives
	function automatic logic [15:0] ectl();
		logic [15:0] v = want_i[15:0], d = 0;
		for (int k = 0; k < 2; k++) begin
			logic [7:0] r = k ? r1 : r0;
			if (!r[7] && r[3:0] inside {[3:7], [9:12], 14, 15}) begin
				d[r[3:0]] |= want_i[16+k];
				v[r[3:0]] &= r[6];
			end
		end
		return v | d;
	endfunction
	task automatic chk(logic [15:0] s, e);
		comparisons++;
		n_mismatch += s !== e;
		if (s !== e) $display("mismatch %0t %h %h", $time, s, e);
	endtask
	task automatic wr(logic [7:0] a, d);
		@(negedge clock_i) {cfg_addr_i, cfg_wdata_i, cfg_wr_i} = {a, d, 1'b1};
		@(negedge clock_i) cfg_wr_i = 0;
	endtask
	task automatic end_of_test;
		$display("errors %0d checks %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		#20000 n_mismatch++;
		end_of_test;
	end
	initial begin
		void'($urandom(57));
		repeat (12) @(negedge clock_i);
		reset_i = 0;
		#1 chk(cfg_rdata_o, 8'h80);
		for (int i = 0; i < 48; i++) begin
			{want_i, r0, r1} = 35'({$urandom, $urandom});
			if (i < 16) r0 = {3'b000, r0[4], 4'(i)};
			r0[7] |= r0[5];
			wr(8'h71, r1);
			wr(8'h72, 8'hff);
			wr(8'h70, r0);
			repeat (4) @(negedge clock_i);
			#1 chk(cfg_rdata_o, r0 & 8'hef);
			chk(ctl_irq_o, ectl());
		end
		end_of_test;
	end
endmodule

// file: hw/bis_route_slice.sv
// One board interrupt input steered onto the controller inputs
`timescale 1ns/100ps
module bis_route_slice
	import bis_pkg::*;
(
	// Configuration
	input wire logic [7:0] route_i,
	// Board interrupt level, already synchronised
	input wire logic irq_i,
	// Contributions to the controller inputs
	output logic [15:0] drive_o,
	output logic [15:0] mask_o
);
	import bis_pkg::*;
	logic [15:0] hot; // Selected line, one-hot
	logic enabled; // Routing active
	// Drive and mask the selected controller input
	always_comb begin
		hot = bis_decode(route_i[BIS_SEL_MSB:0]); // RULE8 RULE9
		enabled = ~route_i[BIS_DIS_BIT]; // RULE1
		// Forward only while enabled, else touch nothing
		drive_o = (enabled && irq_i) ? hot : 16'h0000; // RULE1 RULE11
		// Mask the ISA line when sharing is off
		mask_o = (enabled && !route_i[BIS_SHARE_BIT]) ? hot : 16'h0000; // RULE2 RULE3 RULE11
	end
endmodule

// file: hw/bis_steer.sv
// Board interrupt steering: two route registers and controller input merge
`timescale 1ns/100ps
// Functional notes
// RULE1: Bit 7 zero enables routing, one disables
// RULE2: Bit 6 turns ISA line sharing on
// RULE3: Enabled without sharing masks selected ISA line
// RULE4: Share only with active-high level sources
// RULE5: Shared with PCI line: clear bit 6
// RULE6: Bit 5 set: pin is timer output
// RULE7: Bit 5 clear: pin input sets IDE flag
// RULE8: Selector codes map to lines 3-15, some reserved
// RULE9: Each input routes independently to 11 lines
// RULE10: Registers reset to 80h, read and write
// RULE11: Disabled routing touches nothing; bit 4 reads zero
module bis_steer
	import bis_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// Configuration space byte access
	input wire logic [7:0] cfg_addr_i,
	input wire logic cfg_wr_i,
	input wire logic [7:0] cfg_wdata_i,
	output logic [7:0] cfg_rdata_o,
	// Board interrupt pins (second one is a plain input)
	input wire logic pin0_in_i,
	output logic pin0_out_o,
	output logic pin0_oe_o,
	input wire logic board_irq_in_1_i,
	// Timer interrupt from the internal timer
	input wire logic timer_irq_i,
	// ISA interrupt request lines
	input wire logic [15:0] isa_irq_i,
	// Controller inputs and IDE status set
	output logic [15:0] ctl_irq_o,
	output logic ide_irq_set_o
);
	import bis_pkg::*;
	// Index of the last board input slice
	localparam int BIS_NUMBOARD_FIX = BIS_NUM_BOARD - 1;
	logic [7:0] board_irq_route_0; // First route register
	logic [7:0] board_irq_route_1; // Second route register
	logic [1:0] pin_s1; // First sync stage
	logic [1:0] pin_s2; // Second sync stage
	logic [15:0] isa_s1; // ISA first stage
	logic [15:0] isa_s2; // ISA second stage
	logic [1:0] board_irq; // Effective board inputs
	logic [15:0] drive [BIS_NUMBOARD_FIX:0]; // Board drives per slice
	logic [15:0] mask [BIS_NUMBOARD_FIX:0]; // ISA masks per slice
	logic timer_mode; // Pin works as timer output
	logic [15:0] next_ctl; // Merged controller inputs

	assign timer_mode = board_irq_route_0[BIS_TIMER_BIT];

	// Register writes; bit 4 held at zero
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			board_irq_route_0 <= BIS_ROUTE_RST; // RULE10
			board_irq_route_1 <= BIS_ROUTE_RST; // RULE10
		end else if (cfg_wr_i) begin
			if (cfg_addr_i == BIS_ROUTE0_OFS) begin
				board_irq_route_0 <= cfg_wdata_i & BIS_WR_MASK; // RULE10 RULE11
			end
			if (cfg_addr_i == BIS_ROUTE1_OFS) begin
				board_irq_route_1 <= cfg_wdata_i & BIS_WR_MASK; // RULE10 RULE11
			end
		end
	end

	// Read mux, zero for other offsets
	always_comb begin
		unique case (cfg_addr_i)
			BIS_ROUTE0_OFS: cfg_rdata_o = board_irq_route_0;
			BIS_ROUTE1_OFS: cfg_rdata_o = board_irq_route_1;
			default: cfg_rdata_o = 8'h00;
		endcase
	end

	// Two-stage synchronisers for pins
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			pin_s1 <= 2'h0;
			pin_s2 <= 2'h0;
			isa_s1 <= 16'h0000;
			isa_s2 <= 16'h0000;
		end else begin
			pin_s1 <= {board_irq_in_1_i, pin0_in_i};
			pin_s2 <= pin_s1;
			isa_s1 <= isa_irq_i;
			isa_s2 <= isa_s1;
		end
	end

	// Pin 0 is no input in timer mode
	assign board_irq = {pin_s2[1], pin_s2[0] & ~timer_mode}; // RULE6 RULE7

	// One steering slice per board input
	generate
		for (genvar g = 0; g < BIS_NUM_BOARD; g++) begin : g_slice
			bis_route_slice u_slice (
				.route_i((g == 0) ? board_irq_route_0 : board_irq_route_1),
				.irq_i(board_irq[g]),
				.drive_o(drive[g]),
				.mask_o(mask[g])
			);
		end
	endgenerate

	// Merge: masked ISA lines plus board drives
	always_comb begin
		next_ctl = (isa_s2 & ~(mask[0] | mask[1])) | drive[0] | drive[1]; // RULE3 RULE5
	end

	// Registered outputs and timer pin
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ctl_irq_o <= 16'h0000;
			ide_irq_set_o <= 1'b0;
			pin0_out_o <= 1'b0;
			pin0_oe_o <= 1'b0;
		end else begin
			ctl_irq_o <= next_ctl;
			// IDE flag source follows pin mode
			ide_irq_set_o <= timer_mode ? isa_s2[BIS_IDE_IRQ] : pin_s2[0]; // RULE6 RULE7
			pin0_out_o <= timer_mode & timer_irq_i; // RULE6
			pin0_oe_o <= timer_mode; // RULE6
		end
	end
endmodule

// file: inc/bis_pkg.sv
// Package for the board interrupt steering block: offsets, fields, reset values
package bis_pkg;
	// Configuration space byte offsets
	localparam logic [7:0] BIS_ROUTE0_OFS = 8'h70;
	localparam logic [7:0] BIS_ROUTE1_OFS = 8'h71;
	// Reset value of each routing register
	localparam logic [7:0] BIS_ROUTE_RST = 8'h80;
	// Field positions
	localparam int BIS_DIS_BIT = 7;
	localparam int BIS_SHARE_BIT = 6;
	localparam int BIS_TIMER_BIT = 5;
	localparam int BIS_RSVD_BIT = 4;
	localparam int BIS_SEL_MSB = 3;
	// Controller input width and numbers
	localparam int BIS_NIRQ = 16;
	localparam int BIS_NUM_BOARD = 2;
	localparam int BIS_IDE_IRQ = 15;
	// Mask of bits that software may write (bit 4 reads zero)
	localparam logic [7:0] BIS_WR_MASK = 8'hef;
	// One-hot decode of the selector; reserved codes give no line
	function automatic logic [15:0] bis_decode(input logic [3:0] sel);
		logic [15:0] hot;
		hot = 16'h0000;
		unique case (sel)
			4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
			4'h9, 4'ha, 4'hb, 4'hc, 4'he, 4'hf: hot[sel] = 1'b1;
			default: hot = 16'h0000;
		endcase
		return hot;
	endfunction
endpackage
